//--- verilog/gen_timer_pkg.sv
// Package of constants for the dual 16-bit general timer
package gen_timer_pkg;
	localparam int          CNT_W          = 16;
	localparam int          PRE_W          = 8;
	localparam logic [15:0] COUNT_RESET    = 16'hFFFF;
	localparam logic [15:0] LOAD_RESET     = 16'hFFFF;
	localparam logic [7:0]  PRESCALE_RESET = 8'h00;
	localparam logic [2:0]  CFG_RESET      = 3'h0;
	localparam logic [2:0]  CFG_32_TIMER   = 3'h0;
	localparam logic [2:0]  CFG_32_CLOCK   = 3'h1;
	localparam logic [2:0]  CFG_16_SPLIT   = 3'h4;
	localparam logic [1:0]  MODE_ONE_SHOT  = 2'h1;
	localparam logic [1:0]  MODE_PERIODIC  = 2'h2;
	localparam logic [31:0] CLOCK_START    = 32'h00000001;
	localparam int          SLOW_CLK_HZ    = 32768;
	localparam int          TICK_HZ        = 1;
	localparam int          SLOW_PER_TICK  = SLOW_CLK_HZ / TICK_HZ;

	typedef enum logic [1:0] {
		RUN_IDLE  = 2'b00,
		RUN_COUNT = 2'b01
	} run_state_t;
endpackage : gen_timer_pkg

//--- verilog/split_counter.sv
// One 16-bit down-counter with 8-bit prescaler for split mode
`timescale 1ns/1ps
module split_counter
	import gen_timer_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rstn,
	input  wire logic              active,
	input  wire logic              enable,
	input  wire logic [1:0]        counter_n_mode_field,
	input  wire logic [15:0]       loadValue,
	input  wire logic              loadWrite,
	input  wire logic [7:0]        prescaleValue,
	input  wire logic              stallHold,
	output logic      [15:0]       count,
	output logic      [7:0]        prescale,
	output logic                   timeout,
	output logic                   stopReq
);
	logic atZero;
	assign atZero = (count == 16'h0000) && (prescale == 8'h00);

	// Down count with prescale extension and reload
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			count    <= COUNT_RESET;
			prescale <= PRESCALE_RESET;
		end
		else if (loadWrite)
		begin
			count    <= loadValue;
			prescale <= prescaleValue;
		end
		else if (active && enable && !stallHold)
		begin
			if (atZero)
			begin
				count    <= loadValue;
				prescale <= prescaleValue;
			end
			else if (prescale != 8'h00)
				prescale <= prescale - 8'h01;
			else
			begin
				prescale <= prescaleValue;
				count    <= count - 16'h0001;
			end
		end
	end

	// Timeout pulse and one-shot stop request
	always_comb
	begin
		timeout = active && enable && !stallHold && atZero && !loadWrite;
		stopReq = timeout && (counter_n_mode_field == MODE_ONE_SHOT);
	end
endmodule : split_counter

//--- verilog/dual_16bit_general_timer.sv
// Dual 16-bit general timer with joined 32-bit and clock modes
`timescale 1ns/1ps
// Contract
// - Two 16-bit counters, split or joined 32-bit
// - Trigger outputs ORed into one ADC trigger
// - Reset clears control; counters and loads FFFF
// - Prescale registers reset to zero
// - Config 0 timer, 1 clock, 4 split
// - 32-bit load write fills both loads
// - 32-bit read gives B high, A low
// - A mode field alone selects 32-bit behaviour
// - 32-bit down count, reload, one-shot stops
// - Timeout sets sticky raw and masked flags
// - Trigger only with output trigger enable
// - Load write while running takes next cycle
// - Stall enable freezes counting during stall
// - Clock mode counts up from one
// - 32.768 kHz pin divided to 1 Hz tick
// - Clock match rolls over to zero
// - Clock match sets raw, masked flags
// - Clock mode ignores stall enables
// - Split counters take modes independently
// - 16-bit down count with 8-bit prescaler
// - 16-bit reload both values, one-shot stops
// - Per-counter timeout flags and trigger
module dual_16bit_general_timer
	import gen_timer_pkg::*;
#(parameter int TICK_DIV = SLOW_PER_TICK)
(
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic [2:0]  timer_global_config,
	input  wire logic [1:0]  counter_a_mode_field,
	input  wire logic [1:0]  counter_b_mode_field,
	input  wire logic        aEnableSet,
	input  wire logic        aEnableClear,
	input  wire logic        bEnableSet,
	input  wire logic        bEnableClear,
	input  wire logic        a_output_trigger_enable,
	input  wire logic        b_output_trigger_enable,
	input  wire logic        a_stall_enable,
	input  wire logic        b_stall_enable,
	input  wire logic        clock_mode_enable,
	input  wire logic        stallIn,
	input  wire logic [31:0] loadData,
	input  wire logic        aLoadWrite,
	input  wire logic        bLoadWrite,
	input  wire logic [7:0]  aPrescaleData,
	input  wire logic        aPrescaleWrite,
	input  wire logic [7:0]  bPrescaleData,
	input  wire logic        bPrescaleWrite,
	input  wire logic [31:0] matchData,
	input  wire logic        matchWrite,
	input  wire logic [4:0]  interrupt_mask_reg,
	input  wire logic [4:0]  status_clear_reg,
	input  wire logic        statusClearWrite,
	input  wire logic        capture_pin_zero,
	input  wire logic        otherTriggers,
	output logic             counter_a_enable,
	output logic             counter_b_enable,
	output logic      [31:0] counter_a_value,
	output logic      [15:0] counter_b_value,
	output logic      [4:0]  raw_status_reg,
	output logic      [4:0]  masked_status_reg,
	output logic             interruptOut,
	output logic             adcTrigger
);
	// Status bits: 0 A timeout, 1 B timeout, 3 clock match
	localparam int A_TO = 0;
	localparam int B_TO = 1;
	localparam int CLK_M = 3;

	logic [15:0] loadA;
	logic [15:0] loadB;
	logic [7:0]  preA;
	logic [7:0]  preB;
	logic [31:0] matchVal;
	logic [31:0] wide;
	logic [2:0]  cfgPrev;
	logic [15:0] slowCount;
	logic [15:0] cntA;
	logic [15:0] cntB;
	logic [4:0]  events;
	logic [4:0]  next_raw;
	logic        pinSync1, pinSync2, pinLast, tick;
	logic        mode32, modeClk, split, stallA, stallB;
	logic        to32, match32, toA, toB, stopA, stopB, trigNow;

	assign mode32  = (timer_global_config == CFG_32_TIMER);
	assign modeClk = (timer_global_config == CFG_32_CLOCK);
	assign split   = (timer_global_config == CFG_16_SPLIT);
	// Clock mode overrides stall so time keeps going
	assign stallA = a_stall_enable && stallIn && !clock_mode_enable;
	assign stallB = b_stall_enable && stallIn && !clock_mode_enable;

	// Load registers; 32-bit write splits into halves
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			loadA <= LOAD_RESET;
			loadB <= LOAD_RESET;
		end
		else
		begin
			if (aLoadWrite)
				loadA <= loadData[15:0];
			// Joined modes refuse B writes; A's upper half covers B
			if (aLoadWrite && !split)
				loadB <= loadData[31:16];
			else if (bLoadWrite && split)
				loadB <= loadData[15:0];
		end
	end

	// Prescale and match registers
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			preA     <= PRESCALE_RESET;
			preB     <= PRESCALE_RESET;
			matchVal <= 32'hFFFFFFFF;
		end
		else
		begin
			if (aPrescaleWrite)
				preA <= aPrescaleData;
			if (bPrescaleWrite)
				preB <= bPrescaleData;
			if (matchWrite)
				matchVal <= matchData;
		end
	end

	// Pin synchroniser and 1 Hz divider; pin is slow, edge counted
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			pinSync1  <= 1'b0;
			pinSync2  <= 1'b0;
			pinLast   <= 1'b0;
			slowCount <= 16'h0000;
			tick      <= 1'b0;
		end
		else
		begin
			pinSync1 <= capture_pin_zero;
			pinSync2 <= pinSync1;
			pinLast  <= pinSync2;
			tick     <= 1'b0;
			if (!modeClk || !counter_a_enable)
				slowCount <= 16'h0000;
			else if (pinSync2 && !pinLast)
			begin
				if (slowCount == 16'(TICK_DIV - 1))
				begin
					slowCount <= 16'h0000;
					tick      <= 1'b1;
				end
				else
					slowCount <= slowCount + 16'h0001;
			end
		end
	end

	assign to32    = mode32 && counter_a_enable && !stallA
		&& (wide == 32'h00000000) && !aLoadWrite;
	assign match32 = modeClk && counter_a_enable && tick
		&& (wide == matchVal);

	// Joined 32-bit counter, down for timer, up for clock
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			wide    <= {COUNT_RESET, COUNT_RESET};
			cfgPrev <= CFG_RESET;
		end
		else
		begin
			cfgPrev <= timer_global_config;
			if (modeClk && cfgPrev != CFG_32_CLOCK)
				wide <= CLOCK_START;
			else if (modeClk && matchWrite && !counter_a_enable)
				wide <= matchData;
			else if (mode32 && aLoadWrite)
				wide <= loadData;
			else if (mode32 && counter_a_enable && !stallA)
			begin
				if (wide == 32'h00000000)
					wide <= {loadB, loadA};
				else
					wide <= wide - 32'h00000001;
			end
			else if (match32)
				wide <= 32'h00000000;
			else if (modeClk && counter_a_enable && tick)
				wide <= wide + 32'h00000001;
		end
	end

	// Live load passes the new word, not the old load register
	split_counter u_cnt_a (
		.ref_clk              (ref_clk),
		.rstn                 (rstn),
		.active               (split),
		.enable               (counter_a_enable),
		.counter_n_mode_field (counter_a_mode_field),
		.loadValue            (aLoadWrite ? loadData[15:0] : loadA),
		.loadWrite            (split && aLoadWrite),
		.prescaleValue        (preA),
		.stallHold            (stallA),
		.count                (cntA),
		.prescale             (),
		.timeout              (toA),
		.stopReq              (stopA)
	);

	// Second counter keeps its own mode field in split mode
	split_counter u_cnt_b (
		.ref_clk              (ref_clk),
		.rstn                 (rstn),
		.active               (split),
		.enable               (counter_b_enable),
		.counter_n_mode_field (counter_b_mode_field),
		.loadValue            (bLoadWrite ? loadData[15:0] : loadB),
		.loadWrite            (split && bLoadWrite),
		.prescaleValue        (preB),
		.stallHold            (stallB),
		.count                (cntB),
		.prescale             (),
		.timeout              (toB),
		.stopReq              (stopB)
	);

	// Enable bits; hardware stop after one-shot timeout
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			counter_a_enable <= 1'b0;
			counter_b_enable <= 1'b0;
		end
		else
		begin
			if (aEnableSet)
				counter_a_enable <= 1'b1;
			else if (aEnableClear || stopA || (to32
				&& counter_a_mode_field == MODE_ONE_SHOT))
				counter_a_enable <= 1'b0;
			if (bEnableSet)
				counter_b_enable <= 1'b1;
			else if (bEnableClear || stopB)
				counter_b_enable <= 1'b0;
		end
	end

	// Read view: joined modes put B in the upper half
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			counter_a_value <= {COUNT_RESET, COUNT_RESET};
			counter_b_value <= COUNT_RESET;
		end
		else
		begin
			counter_a_value <= split ? {16'h0000, cntA} : wide;
			counter_b_value <= split ? cntB : wide[31:16];
		end
	end

	assign events = {1'b0, match32, 1'b0, toB && split, (toA && split) || to32};

	assign next_raw = events | (raw_status_reg
		& ~(statusClearWrite ? status_clear_reg : 5'h00));

	// Sticky flags: a new event beats a same-cycle clear
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			raw_status_reg    <= 5'h00;
			masked_status_reg <= 5'h00;
			interruptOut      <= 1'b0;
		end
		else
		begin
			raw_status_reg    <= next_raw;
			masked_status_reg <= next_raw & interrupt_mask_reg;
			interruptOut      <= |(next_raw & interrupt_mask_reg);
		end
	end

	assign trigNow = (events[A_TO] && a_output_trigger_enable)
		|| (events[B_TO] && b_output_trigger_enable);

	// One-cycle ADC trigger, merged with the other timer blocks
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			adcTrigger <= 1'b0;
		else
			adcTrigger <= trigNow || otherTriggers;
	end

	a_timeout_flag: assert property (@(posedge ref_clk)
		disable iff (!rstn) to32 |=> raw_status_reg[A_TO])
		else $error("timeout flag not set");
	a_trigger_gate: assert property (@(posedge ref_clk)
		disable iff (!rstn) adcTrigger
		|-> $past(trigNow) || $past(otherTriggers))
		else $error("trigger without cause");
	a_oneshot_stop: assert property (@(posedge ref_clk)
		disable iff (!rstn) to32 && counter_a_mode_field == MODE_ONE_SHOT
		&& !aEnableSet |=> !counter_a_enable)
		else $error("one-shot did not stop");
	a_reload_wide: assert property (@(posedge ref_clk)
		disable iff (!rstn) to32 |=> wide == {$past(loadB), $past(loadA)})
		else $error("32-bit reload wrong");
	a_load_take: assert property (@(posedge ref_clk)
		disable iff (!rstn) mode32 && aLoadWrite |=> wide == $past(loadData))
		else $error("load not taken");
	a_clock_roll: assert property (@(posedge ref_clk)
		disable iff (!rstn) match32 && !matchWrite && cfgPrev == CFG_32_CLOCK
		|=> wide == 32'h00000000)
		else $error("clock did not roll over");
	a_stall_hold: assert property (@(posedge ref_clk)
		disable iff (!rstn) mode32 && stallA && !aLoadWrite |=> $stable(wide))
		else $error("stall did not hold");
	a_match_flag: assert property (@(posedge ref_clk)
		disable iff (!rstn) match32 |=> raw_status_reg[CLK_M])
		else $error("match flag not set");
endmodule : dual_16bit_general_timer

//--- testbench/tb_dual_16bit_general_timer.sv
// Self-checking bench for the dual 16-bit general timer
`timescale 1ns/1ps
module tb_dual_16bit_general_timer;
	import gen_timer_pkg::*;
	// Short tick divider keeps clock-mode runs brief
	localparam int DIV = 4;
	localparam logic [10:0] EN_A = 11'h001, EN_B = 11'h002, CL_A = 11'h004;
	localparam logic [10:0] CL_B = 11'h008, LD_A = 11'h010, LD_B = 11'h020;
	localparam logic [10:0] PS_A = 11'h040, MW = 11'h080, CLR = 11'h100;
	localparam logic [10:0] OT = 11'h200, PS_B = 11'h400;
	logic        ref_clk = 1'b0, rstn = 1'b0;
	logic [2:0]  timer_global_config = CFG_32_TIMER;
	logic [1:0]  counter_a_mode_field = MODE_ONE_SHOT;
	logic [1:0]  counter_b_mode_field = MODE_ONE_SHOT;
	logic        aEnableSet = 1'b0, bEnableSet = 1'b0;
	logic        aEnableClear = 1'b0, bEnableClear = 1'b0;
	logic        a_output_trigger_enable = 1'b0, b_output_trigger_enable = 1'b0;
	logic        a_stall_enable = 1'b0, b_stall_enable = 1'b0;
	logic        clock_mode_enable = 1'b0, stallIn = 1'b0;
	logic [31:0] loadData = 32'h00000000, matchData = 32'h00000000;
	logic        aLoadWrite = 1'b0, bLoadWrite = 1'b0, matchWrite = 1'b0;
	logic [7:0]  aPrescaleData = 8'h00, bPrescaleData = 8'h00;
	logic        aPrescaleWrite = 1'b0, bPrescaleWrite = 1'b0;
	logic [4:0]  interrupt_mask_reg = 5'h00, status_clear_reg = 5'h00;
	logic        statusClearWrite = 1'b0, capture_pin_zero = 1'b0;
	logic        otherTriggers = 1'b0, pinRun = 1'b0;
	logic        counter_a_enable, counter_b_enable, interruptOut, adcTrigger;
	logic [31:0] counter_a_value, v;
	logic [15:0] counter_b_value;
	logic [4:0]  raw_status_reg, masked_status_reg;
	logic        trig;
	int          err_total = 0, n_compared = 0, trigCnt = 0, t0, nA, nB;

	dual_16bit_general_timer #(.TICK_DIV(DIV)) dut_u (.ref_clk, .rstn,
		.timer_global_config, .counter_a_mode_field, .counter_b_mode_field,
		.aEnableSet, .aEnableClear, .bEnableSet, .bEnableClear,
		.a_output_trigger_enable, .b_output_trigger_enable, .a_stall_enable,
		.b_stall_enable, .clock_mode_enable, .stallIn, .loadData, .aLoadWrite,
		.bLoadWrite, .aPrescaleData, .aPrescaleWrite, .bPrescaleData,
		.bPrescaleWrite, .matchData, .matchWrite, .interrupt_mask_reg,
		.status_clear_reg, .statusClearWrite, .capture_pin_zero,
		.otherTriggers, .counter_a_enable, .counter_b_enable,
		.counter_a_value, .counter_b_value, .raw_status_reg,
		.masked_status_reg, .interruptOut, .adcTrigger);

	// Clock, slow pin stimulus and trigger pulse counter
	always #2.5 ref_clk = ~ref_clk;
	always #20 if (pinRun) capture_pin_zero = ~capture_pin_zero;
	always @(posedge ref_clk) if (adcTrigger === 1'b1) trigCnt <= trigCnt + 1;

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
			err_total++;
		end
	endtask : chk

	// One-cycle pulse on every strobe selected in the mask
	task automatic strobe(input logic [10:0] w);
		{bPrescaleWrite, otherTriggers, statusClearWrite, matchWrite,
			aPrescaleWrite, bLoadWrite, aLoadWrite, bEnableClear,
			aEnableClear, bEnableSet, aEnableSet} = w;
		tick(1);
		{bPrescaleWrite, otherTriggers, statusClearWrite, matchWrite,
			aPrescaleWrite, bLoadWrite, aLoadWrite, bEnableClear,
			aEnableClear, bEnableSet, aEnableSet} = 11'h000;
	endtask : strobe

	// Bounded wait for a raw flag; trigger sampled in the same cycle
	task automatic waitRaw(input int b, input int lim, output int n);
		for (n = 1; n <= lim; n++)
		begin
			tick(1);
			if (raw_status_reg[b] === 1'b1)
			begin
				trig = adcTrigger;
				return;
			end
		end
		$display("[FAIL] wait for flag %0d timed out", b);
		err_total++;
		tally_and_finish();
	endtask : waitRaw

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		tick(12);
		rstn = 1'b1;
		chk("reset value", counter_a_value, 32'hFFFFFFFF);
		chk("reset b", counter_b_value, LOAD_RESET);
		chk("reset enables", {counter_a_enable, counter_b_enable}, 0);
		chk("reset raw", raw_status_reg, 0);
		// Joined load fills both halves; B write refused
		loadData = 32'h12345678;
		strobe(LD_A);
		tick(2);
		chk("joined read", counter_a_value, 32'h12345678);
		chk("b half", counter_b_value, 16'h1234);
		loadData = 32'h0000AAAA;
		strobe(LD_B);
		tick(2);
		chk("b refused", counter_b_value, 16'h1234);
		// 32-bit one-shot; B mode set periodic to show it is ignored
		counter_b_mode_field = MODE_PERIODIC;
		a_output_trigger_enable = 1'b1;
		interrupt_mask_reg = 5'h01;
		loadData = 32'h00000003;
		strobe(LD_A);
		strobe(EN_A);
		waitRaw(0, 20, nA);
		chk("trigger", trig, 1);
		chk("masked a", masked_status_reg[0], 1);
		chk("irq", interruptOut, 1);
		tick(2);
		chk("one-shot stop", counter_a_enable, 0);
		chk("reloaded", counter_a_value, 32'h00000003);
		tick(3);
		chk("sticky raw", raw_status_reg[0], 1);
		status_clear_reg = 5'h01;
		strobe(CLR);
		tick(1);
		chk("cleared", raw_status_reg[0], 0);
		// Periodic, trigger off: repeats with no trigger
		counter_a_mode_field = MODE_PERIODIC;
		a_output_trigger_enable = 1'b0;
		t0 = trigCnt;
		loadData = 32'h00000004;
		strobe(LD_A);
		strobe(EN_A);
		waitRaw(0, 20, nA);
		strobe(CLR);
		waitRaw(0, 20, nA);
		chk("periodic run", counter_a_enable, 1);
		chk("no trigger", trigCnt - t0, 0);
		// Stall freezes, release resumes
		a_stall_enable = 1'b1;
		stallIn = 1'b1;
		tick(2);
		v = counter_a_value;
		tick(6);
		chk("stall hold", counter_a_value, v);
		stallIn = 1'b0;
		tick(3);
		chk("resumed", counter_a_value != v, 1);
		loadData = 32'h00000100;
		strobe(LD_A);
		tick(1);
		chk("live load", counter_a_value, 32'h00000100);
		strobe(CL_A);
		a_stall_enable = 1'b0;
		// Split: A one-shot with prescale 1, B periodic
		timer_global_config = CFG_16_SPLIT;
		counter_a_mode_field = MODE_ONE_SHOT;
		b_output_trigger_enable = 1'b1;
		interrupt_mask_reg = 5'h03;
		status_clear_reg = 5'h1F;
		aPrescaleData = 8'h01;
		strobe(CLR | PS_A | PS_B);
		loadData = 32'h00000003;
		strobe(LD_A);
		loadData = 32'h00000002;
		strobe(LD_B);
		tick(2);
		chk("split a", counter_a_value, 32'h00000003);
		chk("split b", counter_b_value, 16'h0002);
		strobe(EN_A | EN_B);
		waitRaw(1, 20, nB);
		chk("b trigger", trig, 1);
		chk("b masked", masked_status_reg[1], 1);
		waitRaw(0, 20, nA);
		chk("prescaled", nA + nB, 8);
		tick(2);
		chk("a stopped", counter_a_enable, 0);
		chk("b runs", counter_b_enable, 1);
		chk("a reload", counter_a_value, 32'h00000003);
		strobe(CL_B);
		// Clock mode counts up from one, stall ignored
		matchData = 32'h00000003;
		strobe(MW);
		timer_global_config = CFG_32_CLOCK;
		clock_mode_enable = 1'b1;
		tick(2);
		chk("clock start", counter_a_value, CLOCK_START);
		a_stall_enable = 1'b1;
		b_stall_enable = 1'b1;
		stallIn = 1'b1;
		interrupt_mask_reg = 5'h08;
		strobe(CLR);
		pinRun = 1'b1;
		strobe(EN_A);
		waitRaw(3, 400, nA);
		chk("match masked", masked_status_reg[3], 1);
		chk("match irq", interruptOut, 1);
		chk("tick rate", nA >= 40, 1);
		tick(2);
		chk("rollover", counter_a_value, 32'h00000000);
		status_clear_reg = 5'h08;
		strobe(CLR);
		tick(1);
		chk("match clear", raw_status_reg[3], 0);
		tick(40);
		chk("keeps counting", counter_a_value, 32'h00000001);
		chk("clock enabled", counter_a_enable, 1);
		// Triggers of other blocks merge into one output
		t0 = trigCnt;
		strobe(OT);
		tick(3);
		chk("merged trigger", trigCnt - t0, 1);
		tally_and_finish();
	end
endmodule : tb_dual_16bit_general_timer
